// file: bench/ioc_host_irq.sv
`timescale 1ns/1ns

// =====================================================================
// Host side of the interrupt pin: a shared line with a pull-up.
module ioc_host_irq (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        pin_o,
    input  wire logic        pin_oe_n,
    output logic             wire_lvl,
    output logic [15:0]      edge_cnt
);
    logic last_q;

    // A released driver leaves the line to the pull-up.
    assign wire_lvl = pin_oe_n ? 1'b1 : pin_o;

    // Edges are counted so that a clock on the pin can be seen.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            last_q   <= 1'b1;
            edge_cnt <= 16'h0000;
        end else begin
            last_q <= wire_lvl;
            if (last_q != wire_lvl) begin
                edge_cnt <= edge_cnt + 16'h0001;
            end
        end
    end
endmodule : ioc_host_irq

// file: bench/tb_irq_output_config_deassert.sv
`timescale 1ns/1ns
`include "ioc_consts.svh"

module tb_irq_output_config_deassert;
    logic                    pclk, presetn, psel, penable, pwrite;
    logic                    soft_rst, pme, pready, pslverr;
    logic [`IOC_ADDR_W-1:0]  paddr;
    logic [31:0]             pwdata, prdata, r;
    logic [3:0]              pstrb;
    logic [`IOC_NUM_SRC-1:0] src_event;
    logic                    irq_line, pin_o, pin_oe_n, wire_lvl, e;
    logic [15:0]             edge_cnt, e0;
    logic [1:0]              xdiv_q = 2'h0;
    logic [31:0]             cfgs [5] = '{32'h101, 32'h100, 32'h110,
                                          32'h010, 32'h011};
    logic                    exps [5] = '{1'b0, 1'b0, 1'b0, 1'b1, 1'b0};
    int                      failures, cmp_count;
    int                      cycles = 0;

    ioc_irq_out i_ioc_irq_out (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .src_event(src_event), .power_mgmt_event(pme),
        .soft_rst(soft_rst), .xtal_clk(xdiv_q[1]), .irq_line(irq_line),
        .irq_pin_o(pin_o), .irq_pin_oe_n(pin_oe_n));

    ioc_host_irq i_ioc_host_irq (
        .pclk(pclk), .presetn(presetn), .pin_o(pin_o),
        .pin_oe_n(pin_oe_n), .wire_lvl(wire_lvl), .edge_cnt(edge_cnt));

    // =================================================================
    // Clock, free-running crystal and watchdog.
    initial begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end

    always @(posedge pclk) begin
        xdiv_q <= xdiv_q + 2'h1;
        cycles++;
        if (cycles == 20000) begin
            failures++;
            finish_test();
        end
    end

    // =================================================================
    // Bus and check tasks.
    task automatic apb(input logic wr, input logic [7:0] a,
                       input logic [31:0] d, output logic [31:0] rd,
                       output logic err);
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic check_word(string nm, logic [31:0] x, logic [31:0] g);
        cmp_count++;
        if (g !== x) begin
            failures++;
            $display("[ERR] %s expected %h seen %h", nm, x, g);
        end
    endtask : check_word

    task automatic check_bit(string nm, logic x, logic g);
        cmp_count++;
        if (g !== x) begin
            failures++;
            $display("[ERR] %s expected %b seen %b", nm, x, g);
        end
    endtask : check_bit

    task automatic wr(logic [7:0] a, logic [31:0] d);
        apb(1'b1, a, d, r, e);
    endtask : wr

    task automatic rd(logic [7:0] a, logic [31:0] x);
        apb(1'b0, a, 32'h0, r, e);
        check_word("rdata", x, r);
    endtask : rd

    task automatic pulse(logic [8:0] v);
        @(posedge pclk);
        src_event <= v[7:0];
        pme       <= v[8];
        @(posedge pclk);
        src_event <= 8'h00;
        pme       <= 1'b0;
    endtask : pulse

    task automatic pin_chk(logic x);
        repeat (3) @(posedge pclk);
        #1;
        check_bit("irq_wire", x, wire_lvl);
    endtask : pin_chk

    task automatic finish_test();
        $display("comparisons %0d mismatches %0d", cmp_count, failures);
        if (failures == 0 && cmp_count > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : finish_test

    // =================================================================
    // Test sequence.
    initial begin
        {presetn, psel, penable, pwrite, soft_rst, pme} = 6'h00;
        {paddr, pwdata, src_event} = '0;
        pstrb = 4'hF;
        failures = 0;
        cmp_count = 0;
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        rd(`IOC_OFF_CFG, 32'h0);
        rd(`IOC_OFF_EN, 32'h0);
        apb(1'b0, 8'h60, 32'h0, r, e);
        check_bit("slverr", 1'b1, e);
        $display("test reset done");

        wr(`IOC_OFF_CFG, 32'h111);
        wr(`IOC_OFF_EN, 32'h001);
        pulse(9'h001);
        pin_chk(1'b1);
        wr(`IOC_OFF_EN, 32'h000);
        pin_chk(1'b0);
        wr(`IOC_OFF_EN, 32'h101);
        pin_chk(1'b1);
        wr(`IOC_OFF_STS, 32'h1FF);
        pin_chk(1'b0);
        $display("test raise mask clear done");

        wr(`IOC_OFF_CFG, 32'h01000111);
        pulse(9'h001);
        pin_chk(1'b1);
        wr(`IOC_OFF_STS, 32'h1FF);
        rd(`IOC_OFF_CFG, 32'h01002111);
        pulse(9'h001);
        pin_chk(1'b0);
        check_bit("irq_line", 1'b1, irq_line);
        repeat (900) @(posedge pclk);
        pin_chk(1'b0);
        repeat (150) @(posedge pclk);
        pin_chk(1'b1);
        $display("test hold-off expiry done");

        wr(`IOC_OFF_STS, 32'h1FF);
        pulse(9'h100);
        pin_chk(1'b1);
        wr(`IOC_OFF_STS, 32'h100);
        pulse(9'h001);
        pin_chk(1'b0);
        wr(`IOC_OFF_CFG, 32'h00000111);
        pin_chk(1'b1);
        rd(`IOC_OFF_CFG, 32'h00001111);
        $display("test bypass and zero done");

        // The clear bit starts an interval, and restarts one that is running.
        wr(`IOC_OFF_CFG, 32'h01004111);
        rd(`IOC_OFF_CFG, 32'h01003111);
        wr(`IOC_OFF_STS, 32'h001);
        repeat (600) @(posedge pclk);
        wr(`IOC_OFF_CFG, 32'h02004111);
        pulse(9'h001);
        rd(`IOC_OFF_CFG, 32'h02003111);
        repeat (1500) @(posedge pclk);
        pin_chk(1'b0);
        repeat (600) @(posedge pclk);
        pin_chk(1'b1);
        $display("test restart done");

        for (int i = 0; i < 5; i++) begin
            wr(`IOC_OFF_CFG, cfgs[i]);
            pin_chk(exps[i]);
        end
        pulse(9'h002);
        check_bit("irq_line", 1'b1, irq_line);
        rd(`IOC_OFF_STS, 32'h003);
        wr(`IOC_OFF_CFG, 32'h00FF8EEC);
        rd(`IOC_OFF_CFG, 32'h00001000);
        wr(`IOC_OFF_CFG, 32'h01000111);
        @(posedge pclk);
        soft_rst <= 1'b1;
        @(posedge pclk);
        soft_rst <= 1'b0;
        rd(`IOC_OFF_CFG, 32'h00000011);
        rd(`IOC_OFF_EN, 32'h0);
        $display("test pin modes done");

        // The clock goes out on the pin in push-pull, then in open-drain.
        wr(`IOC_OFF_CFG, 32'h00000003);
        e0 = edge_cnt;
        repeat (40) @(posedge pclk);
        check_bit("clk_on_pin", 1'b1, (edge_cnt - e0) > 16'h0008);
        wr(`IOC_OFF_CFG, 32'h00000002);
        e0 = edge_cnt;
        repeat (40) @(posedge pclk);
        check_bit("clk_od_pin", 1'b1, (edge_cnt - e0) > 16'h0008);
        $display("test clock out done");
        finish_test();
    end
endmodule : tb_irq_output_config_deassert

// file: hw/ioc_consts.svh
`ifndef IOC_CONSTS_SVH
`define IOC_CONSTS_SVH

// =====================================================================
// Register offsets (byte addresses on the APB bus).
`define IOC_ADDR_W         8
`define IOC_OFF_CFG        8'h54
`define IOC_OFF_STS        8'h58
`define IOC_OFF_EN         8'h5C

// =====================================================================
// Field positions of the pin configuration register.
`define IOC_CFG_IVL_LSB    24
`define IOC_CFG_CLR        14
`define IOC_CFG_HSTS       13
`define IOC_CFG_GINT       12
`define IOC_CFG_IRQEN      8
`define IOC_CFG_POL        4
`define IOC_CFG_CLKSEL     1
`define IOC_CFG_TYPE       0

// =====================================================================
// Status and enable layout: general sources low, power event above.
`define IOC_NUM_SRC        8
`define IOC_PME_BIT        8
`define IOC_STS_W          9

// =====================================================================
// Reset values.
`define IOC_RST_IVL        8'h00
`define IOC_RST_BIT        1'b0
`define IOC_RST_STS        9'h000

// =====================================================================
// Timing.
`define IOC_CLK_PERIOD_NS  10
`define IOC_HOLD_UNIT_NS   10000
`define IOC_HOLD_UNIT_CYC  (`IOC_HOLD_UNIT_NS / `IOC_CLK_PERIOD_NS)
`define IOC_PRE_W          10
`define IOC_RUN_W          18

`endif

// file: hw/ioc_holdoff.sv
`timescale 1ns/1ns
`include "ioc_consts.svh"

module ioc_holdoff
    import ioc_pkg::*;
(
    input  wire logic     pclk,
    input  wire logic     presetn,
    input  wire logic     soft_rst,
    input  wire ioc_ivl_t interval,
    input  wire logic     start,
    input  wire logic     restart,
    output logic          active
);

    localparam logic [`IOC_PRE_W-1:0] PRE_LAST =
        `IOC_PRE_W'(`IOC_HOLD_UNIT_CYC - 1);

    ioc_hold_e                 st_q;
    ioc_hold_e                 st_d;
    logic [`IOC_PRE_W-1:0]     pre_q;
    logic [`IOC_PRE_W-1:0]     pre_d;
    ioc_ivl_t                  units_q;
    ioc_ivl_t                  units_d;

    wire logic disable_w = soft_rst | (interval == 8'h00);
    wire logic load_w    = start | restart;
    wire logic unit_end  = (pre_q == PRE_LAST);
    wire logic expire_w  = unit_end & (units_q == 8'h01);

    assign active = (st_q == IOC_HOLD_RUN);

    // =================================================================
    // Interval sequencer: the prescaler counts one 10 us unit, the unit
    // counter counts units down from the value latched at the start.
    always_comb begin
        st_d    = st_q;
        pre_d   = pre_q;
        units_d = units_q;
        if (disable_w) begin
            st_d    = IOC_HOLD_IDLE;
            pre_d   = '0;
            units_d = '0;
        end else if (load_w) begin
            st_d    = IOC_HOLD_RUN;
            pre_d   = '0;
            units_d = interval;
        end else begin
            case (st_q)
                IOC_HOLD_RUN: begin
                    if (expire_w) begin
                        st_d    = IOC_HOLD_IDLE;
                        pre_d   = '0;
                        units_d = '0;
                    end else if (unit_end) begin
                        pre_d   = '0;
                        units_d = units_q - 8'h01;
                    end else begin
                        pre_d   = pre_q + `IOC_PRE_W'(1);
                    end
                end
                IOC_HOLD_IDLE: begin
                    st_d = IOC_HOLD_IDLE;
                end
                default: begin
                    st_d = IOC_HOLD_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_q    <= IOC_HOLD_IDLE;
            pre_q   <= '0;
            units_q <= '0;
        end else begin
            st_q    <= st_d;
            pre_q   <= pre_d;
            units_q <= units_d;
        end
    end

    // =================================================================
    // Checking: an undisturbed interval lasts exactly interval units.
    logic [`IOC_RUN_W-1:0] run_q;
    logic [`IOC_RUN_W-1:0] total_q;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            run_q   <= '0;
            total_q <= '0;
        end else if (load_w && !disable_w) begin
            run_q   <= '0;
            total_q <= `IOC_RUN_W'(interval * `IOC_HOLD_UNIT_CYC);
        end else if (active) begin
            run_q   <= run_q + `IOC_RUN_W'(1);
        end
    end

    interval_length_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        $fell(active) && $past(interval) != 8'h00 && !$past(soft_rst)
        |-> run_q == total_q)
        else $error("Hold-off interval length is wrong.");

endmodule : ioc_holdoff

// file: hw/ioc_irq_out.sv
// Implementation choice: the APB interface to the registers.
`timescale 1ns/1ns
`include "ioc_consts.svh"


module ioc_irq_out
    import ioc_pkg::*;
(
    input  wire logic                   pclk,
    input  wire logic                   presetn,
    input  wire logic                   psel,
    input  wire logic                   penable,
    input  wire logic                   pwrite,
    input  wire logic [`IOC_ADDR_W-1:0] paddr,
    input  wire logic [31:0]            pwdata,
    input  wire logic [3:0]             pstrb,
    output logic      [31:0]            prdata,
    output logic                        pready,
    output logic                        pslverr,
    input  wire logic [`IOC_NUM_SRC-1:0] src_event,
    input  wire logic                   power_mgmt_event,
    input  wire logic                   soft_rst,
    input  wire logic                   xtal_clk,
    output logic                        irq_line,
    output logic                        irq_pin_o,
    output logic                        irq_pin_oe_n
);

    // =================================================================
    // Registers.
    ioc_ivl_t   ivl_q;
    logic       clr_q;
    logic       irq_en_q;
    logic       pol_q;
    logic       clk_sel_q;
    logic       type_q;
    ioc_src_t   sts_q;
    ioc_src_t   en_q;
    logic       fwd_q;
    logic       xtal_s1_q;
    logic       xtal_s2_q;
    logic       xtal_s3_q;
    logic       xtal_q;
    logic       pin_o_q;
    logic       pin_oe_n_q;
    logic       irq_line_q;
    logic [31:0] prdata_q;
    logic       pready_q;
    logic       pslverr_q;
    logic       hold_active;

    // =================================================================
    // APB decode.
    wire logic setup_w  = psel & ~penable;
    wire logic access_w = psel & penable & pready_q;
    wire logic hit_cfg  = (paddr == `IOC_OFF_CFG);
    wire logic hit_sts  = (paddr == `IOC_OFF_STS);
    wire logic hit_en   = (paddr == `IOC_OFF_EN);
    wire logic hit_any  = hit_cfg | hit_sts | hit_en;
    wire logic wr_w     = access_w & pwrite;

    logic [3:0]  wcfg;
    logic [31:0] wmask;

    genvar gi;
    generate
        for (gi = 0; gi < 4; gi = gi + 1) begin : g_lane
            assign wcfg[gi]           = wr_w & hit_cfg & pstrb[gi];
            assign wmask[8*gi +: 8]   = {8{pstrb[gi]}};
        end
    endgenerate

    wire ioc_src_t sts_clr = (wr_w & hit_sts) ?
                             (pwdata[`IOC_STS_W-1:0] & wmask[`IOC_STS_W-1:0])
                             : '0;
    wire ioc_src_t sts_set = {power_mgmt_event, src_event};
    wire logic     wr_en   = wr_w & hit_en;

    // =================================================================
    // Combined line and hold-off gating.
    wire ioc_src_t act_w    = sts_q & en_q;
    wire logic     line_all = |act_w;
    wire logic     line_gen = |act_w[`IOC_NUM_SRC-1:0];
    wire logic     pme_w    = act_w[`IOC_PME_BIT];
    wire logic     fwd_w    = irq_en_q & line_gen & ~hold_active;
    wire logic     assert_w = fwd_w | (irq_en_q & pme_w);
    wire logic     start_w  = fwd_q & ~line_gen;

    // Push-pull follows polarity; open-drain only pulls low.
    wire logic pin_o_d    = type_q &
                            (clk_sel_q ? xtal_q : ~(assert_w ^ pol_q));
    wire logic pin_oe_n_d = ~type_q &
                            (clk_sel_q ? xtal_q : ~assert_w);

    wire logic [31:0] cfg_rd = {ivl_q, 9'h000, 1'b0, hold_active,
                                line_all, 3'h0, irq_en_q, 3'h0, pol_q,
                                2'h0, clk_sel_q, type_q};
    wire logic [31:0] rd_mux = hit_cfg ? cfg_rd :
                               hit_sts ? {23'h000000, sts_q} :
                               hit_en  ? {23'h000000, en_q} : 32'h00000000;

    ioc_holdoff u_holdoff (
        .pclk     (pclk),
        .presetn  (presetn),
        .soft_rst (soft_rst),
        .interval (ivl_q),
        .start    (start_w),
        .restart  (clr_q),
        .active   (hold_active)
    );

    // =================================================================
    // Bus slave: zero wait states, data latched in the setup cycle.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_q  <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q  <= 32'h00000000;
        end else begin
            pready_q  <= setup_w;
            if (setup_w) begin
                pslverr_q <= ~hit_any;
                prdata_q  <= rd_mux;
            end
        end
    end

    // =================================================================
    // Configuration register.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ivl_q     <= `IOC_RST_IVL;
            clr_q     <= `IOC_RST_BIT;
            irq_en_q  <= `IOC_RST_BIT;
            clk_sel_q <= `IOC_RST_BIT;
        end else if (soft_rst) begin
            ivl_q     <= `IOC_RST_IVL;
            clr_q     <= `IOC_RST_BIT;
            irq_en_q  <= `IOC_RST_BIT;
            clk_sel_q <= `IOC_RST_BIT;
        end else begin
            clr_q <= wcfg[1] & pwdata[`IOC_CFG_CLR];
            if (wcfg[3]) begin
                ivl_q <= pwdata[`IOC_CFG_IVL_LSB +: 8];
            end
            if (wcfg[1]) begin
                irq_en_q <= pwdata[`IOC_CFG_IRQEN];
            end
            if (wcfg[0]) begin
                clk_sel_q <= pwdata[`IOC_CFG_CLKSEL];
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pol_q  <= `IOC_RST_BIT;
            type_q <= `IOC_RST_BIT;
        end else if (wcfg[0] && !soft_rst) begin
            pol_q  <= pwdata[`IOC_CFG_POL];
            type_q <= pwdata[`IOC_CFG_TYPE];
        end
    end

    // =================================================================
    // Sticky status (set wins over clear) and source enables.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sts_q <= `IOC_RST_STS;
            en_q  <= `IOC_RST_STS;
        end else if (soft_rst) begin
            sts_q <= sts_set;
            en_q  <= `IOC_RST_STS;
        end else begin
            sts_q <= (sts_q & ~sts_clr) | sts_set;
            if (wr_en) begin
                en_q <= (en_q & ~wmask[`IOC_STS_W-1:0]) |
                        (pwdata[`IOC_STS_W-1:0] & wmask[`IOC_STS_W-1:0]);
            end
        end
    end

    // =================================================================
    // Crystal clock sampling: updates once the last two stages agree.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            xtal_s1_q <= 1'b0;
            xtal_s2_q <= 1'b0;
            xtal_s3_q <= 1'b0;
            xtal_q    <= 1'b0;
        end else begin
            xtal_s1_q <= xtal_clk;
            xtal_s2_q <= xtal_s1_q;
            xtal_s3_q <= xtal_s2_q;
            if (xtal_s2_q == xtal_s3_q) begin
                xtal_q <= xtal_s3_q;
            end
        end
    end

    // =================================================================
    // Pin driver and interrupt line.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            fwd_q      <= 1'b0;
            pin_o_q    <= 1'b0;
            pin_oe_n_q <= 1'b1;
            irq_line_q <= 1'b0;
        end else begin
            fwd_q      <= fwd_w;
            pin_o_q    <= pin_o_d;
            pin_oe_n_q <= pin_oe_n_d;
            irq_line_q <= line_all;
        end
    end

    assign prdata       = prdata_q;
    assign pready       = pready_q;
    assign pslverr      = pslverr_q;
    assign irq_line     = irq_line_q;
    assign irq_pin_o    = pin_o_q;
    assign irq_pin_oe_n = pin_oe_n_q;

    // =================================================================
    // Checks.
    disabled_od_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        !irq_en_q && !clk_sel_q && !type_q |=> irq_pin_oe_n)
        else $error("Disabled open-drain pin is driven.");

    disabled_pp_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        !irq_en_q && !clk_sel_q && type_q
        |=> irq_pin_o == !$past(pol_q) && !irq_pin_oe_n)
        else $error("Disabled push-pull pin shows an active level.");

    od_level_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        !type_q |=> !irq_pin_o)
        else $error("Open-drain pin data is not low.");

    pp_drive_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        type_q |=> !irq_pin_oe_n)
        else $error("Push-pull pin is not driven.");

    clk_route_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        clk_sel_q && type_q |=> irq_pin_o == $past(xtal_q))
        else $error("Crystal clock not routed to pin.");

    pme_bypass_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        irq_en_q && pme_w && hold_active && !clk_sel_q
        |=> ($past(type_q) ? irq_pin_o == $past(pol_q) : !irq_pin_oe_n))
        else $error("Power event held off by interval.");

    holdoff_gate_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        hold_active && !pme_w && !clk_sel_q
        |=> ($past(type_q) ? irq_pin_o == !$past(pol_q) : irq_pin_oe_n))
        else $error("Interrupt passed during hold-off.");

    zero_disable_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        ivl_q == 8'h00 |=> !hold_active)
        else $error("Hold-off active with zero interval.");

    clear_restart_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        clr_q && ivl_q != 8'h00 && !soft_rst |=> hold_active ##1 !clr_q)
        else $error("Interval clear did not restart hold-off.");

    pending_release_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        $fell(hold_active) && irq_en_q && line_gen && !clk_sel_q
        |=> ($past(type_q) ? irq_pin_o == $past(pol_q) : !irq_pin_oe_n))
        else $error("Pending interrupt not released after interval.");

    cfg_read_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        setup_w && hit_cfg
        |=> prdata[`IOC_CFG_GINT] == $past(line_all)
            && prdata[`IOC_CFG_HSTS] == $past(hold_active)
            && prdata[23:15] == 9'h000 && prdata[11:9] == 3'h0)
        else $error("Configuration read data wrong.");

    soft_keep_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        soft_rst |=> pol_q == $past(pol_q) && type_q == $past(type_q)
                     && !irq_en_q && ivl_q == 8'h00)
        else $error("Soft reset handling of configuration wrong.");

endmodule : ioc_irq_out

// file: hw/ioc_pkg.sv
`include "ioc_consts.svh"

package ioc_pkg;

    typedef enum logic {
        IOC_HOLD_IDLE,
        IOC_HOLD_RUN
    } ioc_hold_e;

    typedef logic [7:0]              ioc_ivl_t;
    typedef logic [`IOC_STS_W-1:0]   ioc_src_t;

endpackage : ioc_pkg
